//--- tb/pcr_rationing_checker.sv
`timescale 1ns/1ps
module pcr_rationing_checker #(
    parameter DELTA_W = 16,
    parameter UPDATE_CYCLES = 20
) (
    // clock, reset, register port
    input wire clk_sys,
    input wire arst_n,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    input wire [7:0] reg_rdata_q,
    // power and charge
    input wire power_active,
    input wire [DELTA_W-1:0] port1_charge_delta,
    input wire [DELTA_W-1:0] port2_charge_delta,
    // status and responses
    input wire port1_quota_hit_flag,
    input wire port2_quota_hit_flag,
    input wire port1_alert_req,
    input wire port2_alert_req,
    input wire port1_switch_open,
    input wire port2_switch_open,
    input wire sleep_req
);
    reg [7:0] cfg_q;
    reg [3:0] idle_q;
    wire cfg_wr = reg_wr && reg_addr == 8'h22;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= 8'h11;
            idle_q <= 4'h0;
        end else begin
            if (cfg_wr) cfg_q <= reg_wdata;
            idle_q <= power_active ? 4'h0 : (idle_q == 4'hf ? idle_q : idle_q + 4'h1);
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_p1_release: assert property (
        cfg_wr && (!reg_wdata[3] || reg_wdata[2]) |-> ##[1:3]
        !port1_quota_hit_flag && !port1_alert_req && !port1_switch_open) else $error("port 1 not released");
    a_p2_release: assert property (
        cfg_wr && (!reg_wdata[7] || reg_wdata[6]) |-> ##[1:3]
        !port2_quota_hit_flag && !port2_alert_req && !port2_switch_open) else $error("port 2 not released");
    a_flag_holds: assert property (
        port1_quota_hit_flag && cfg_q[3] && !cfg_q[2] && !cfg_wr |=> port1_quota_hit_flag)
        else $error("port 1 flag dropped");
    a_alert_flag: assert property (port1_alert_req |-> port1_quota_hit_flag)
        else $error("alert without flag");
    a_ignore_quiet: assert property (
        $rose(port1_quota_hit_flag) && cfg_q[1:0] == 2'h3 |-> !port1_alert_req && !port1_switch_open)
        else $error("ignore response acted");
    a_report_only: assert property (
        $rose(port1_quota_hit_flag) && cfg_q[1:0] == 2'h0 |-> port1_alert_req && !port1_switch_open)
        else $error("report response wrong");
    a_sleep_opens: assert property (sleep_req |-> port1_switch_open || port2_switch_open)
        else $error("sleep without open switch");
    a_idle_no_hit: assert property (
        idle_q > 4'h4 |-> !$rose(port1_quota_hit_flag) && !$rose(port2_quota_hit_flag))
        else $error("hit while not active");
    a_pad_zero: assert property (
        reg_rd && (reg_addr == 8'h19 || reg_addr == 8'h1d) |=> reg_rdata_q[5:0] == 6'h00)
        else $error("pad bits not zero");
endmodule
bind pcr_rationing pcr_rationing_checker #(.DELTA_W(DELTA_W), .UPDATE_CYCLES(UPDATE_CYCLES)) chk_i (
    .clk_sys, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_q, .power_active,
    .port1_charge_delta, .port2_charge_delta, .port1_quota_hit_flag, .port2_quota_hit_flag,
    .port1_alert_req, .port2_alert_req, .port1_switch_open, .port2_switch_open, .sleep_req);

//--- tb/pcr_rationing_tb.sv
`timescale 1ns/1ps
module pcr_rationing_tb;
    localparam UC = 20;
    reg clk_sys = 0;
    reg arst_n = 0;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 0, reg_rd = 0, power_active = 0;
    reg [15:0] d1 = 0, d2 = 0;
    reg [31:0] seed = 93;
    wire [7:0] rdq;
    wire f1, f2, a1, a2, o1, o2, slp;
    integer fails = 0, n_checks = 0, r, m1, m2;
    // reference model: tick phase, per-port totals and the last config byte written
    integer tk = 0, mt1 = 0, mt2 = 0;
    reg [7:0] mcfg = 8'h11;
    pcr_rationing #(.DELTA_W(16), .UPDATE_CYCLES(UC)) pcr_rationing_i (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(rdq),
        .power_active(power_active), .port1_charge_delta(d1), .port2_charge_delta(d2),
        .port1_quota_hit_flag(f1), .port2_quota_hit_flag(f2), .port1_alert_req(a1), .port2_alert_req(a2),
        .port1_switch_open(o1), .port2_switch_open(o2), .sleep_req(slp));
    initial forever #50 clk_sys = ~clk_sys;
    function [31:0] xs(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("wrong value at %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk_sys);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1;
            @(negedge clk_sys);
            reg_wr = 0;
            // disable or clear zeroes the model total straight away
            if (a == 8'h22) begin
                mcfg = d;
                if (!d[3] || d[2]) mt1 = 0;
                if (!d[7] || d[6]) mt2 = 0;
            end
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(negedge clk_sys);
            reg_addr = a;
            reg_rd = 1;
            @(negedge clk_sys);
            reg_rd = 0;
            chk({24'h0, rdq}, {24'h0, e});
        end
    endtask
    // first byte snapshots the word, so bytes go in address order
    task rtot(input [7:0] a, input integer t);
        reg [31:0] w;
        begin
            w = {t[25:0], 6'h00};
            rd(a, w[31:24]);
            rd(a + 8'h1, w[23:16]);
            rd(a + 8'h2, w[15:8]);
            rd(a + 8'h3, w[7:0]);
        end
    endtask
    // lower bytes only, so they must still come from the earlier first-byte snapshot
    task rsnap(input [7:0] a, input integer t);
        reg [31:0] w;
        begin
            w = {t[25:0], 6'h00};
            rd(a + 8'h1, w[23:16]);
            rd(a + 8'h2, w[15:8]);
            rd(a + 8'h3, w[7:0]);
        end
    endtask
    task outs(input [6:0] e);
        chk({25'h0, f1, f2, a1, a2, o1, o2, slp}, {25'h0, e});
    endtask
    // run length keeps the update phase mid-window, so an off-by-one tick cannot land on a read
    task run(input integer n);
        begin
            power_active = 1;
            repeat (n) begin
                @(negedge clk_sys);
                // one update per UC active edges, only for an enabled port with clear low
                if (tk == UC - 1) begin
                    tk = 0;
                    if (mcfg[3] && !mcfg[2]) mt1 = mt1 + d1;
                    if (mcfg[7] && !mcfg[6]) mt2 = mt2 + d2;
                end else begin
                    tk = tk + 1;
                end
            end
            power_active = 0;
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        #2000000;
        fails = fails + 1;
        stop_test;
    end
    initial begin
        repeat (20) @(negedge clk_sys);
        arst_n = 1;
        rd(8'h22, 8'h11);
        rd(8'h1e, 8'hff);
        rd(8'h21, 8'hff);
        rd(8'h30, 8'h00);
        wr(8'h16, 8'h55);
        wr(8'h22, 8'h00);
        run(UC / 2);
        rtot(8'h16, 0);
        $display("test reset done");
        for (r = 0; r < 4; r = r + 1) begin
            seed = xs(seed);
            d1 = 16'h0400 + seed[13:0];
            seed = xs(seed);
            d2 = 16'h0400 + seed[13:0];
            m1 = (3 * d1) >> 10;
            m2 = (3 * d2) >> 10;
            wr(8'h1e, m1[15:8]);
            wr(8'h1f, m1[7:0]);
            wr(8'h20, m2[15:8]);
            wr(8'h21, m2[7:0]);
            rd(8'h1f, m1[7:0]);
            wr(8'h22, {2'b10, r[1:0] ^ 2'h1, 2'b10, r[1:0]});
            run(2 * UC);
            rtot(8'h16, mt1);
            rtot(8'h1a, mt2);
            outs(7'h00);
            run(2 * UC);
            rsnap(8'h16, 2 * d1);
            rtot(8'h16, mt1);
            rtot(8'h1a, mt2);
            outs({2'b11, r < 2, (r ^ 1) < 2, r == 1 || r == 2, r == 0 || r == 3, r >= 2});
            if (r[0]) wr(8'h22, 8'h00);
            else wr(8'h22, 8'hcc);
            run(2 * UC);
            outs(7'h00);
            rtot(8'h16, 0);
            rtot(8'h1a, 0);
            wr(8'h22, 8'h00);
            $display("test response %0d done", r);
        end
        stop_test;
    end
endmodule

//--- verilog/pcr_consts.vh
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH

// byte addresses of the ration register window
`define PCR_ADDR_P1_TOTAL 8'h16
`define PCR_ADDR_P2_TOTAL 8'h1a
`define PCR_ADDR_P1_THRESH 8'h1e
`define PCR_ADDR_P2_THRESH 8'h20
`define PCR_ADDR_CONFIG 8'h22

// byte positions inside a multi-byte register, most significant first
`define PCR_BYTE1 8'h01
`define PCR_BYTE2 8'h02
`define PCR_BYTE3 8'h03

// ration configuration byte layout, per port nibble
`define PCR_CFG_NIBBLE 4
`define PCR_CFG_RESP_LSB 0
`define PCR_CFG_CLEAR_BIT 2
`define PCR_CFG_ENABLE_BIT 3

// reset values
`define PCR_CONFIG_RESET 8'h11
`define PCR_THRESH_RESET 16'hffff

// widths
`define PCR_TOTAL_W 26
`define PCR_THRESH_W 16
`define PCR_PAD_BITS 6
`define PCR_SCALE_SHIFT 10

// response encodings
`define PCR_RESP_REPORT 2'h0
`define PCR_RESP_REPORT_DISC 2'h1
`define PCR_RESP_DISC_SLEEP 2'h2
`define PCR_RESP_IGNORE 2'h3

// update period
`define PCR_UPDATE_TIME_NS 1000000000
`define PCR_CLK_PERIOD_NS 100

`endif

//--- verilog/pcr_port_unit.v
`timescale 1ns/1ps
`include "pcr_consts.vh"

module pcr_port_unit #(
    parameter DELTA_W = 16
) (
    // clock and reset
    input wire clk_sys,
    input wire arst_n,
    // control
    input wire update,
    input wire quota_enable,
    input wire quota_clear,
    input wire [1:0] quota_response,
    input wire [`PCR_THRESH_W-1:0] threshold,
    input wire [DELTA_W-1:0] charge_delta,
    // state
    output reg [`PCR_TOTAL_W-1:0] total_q,
    output reg hit_q,
    output reg alert_q,
    output reg open_q,
    output reg sleep_q
);

    wire active_w;
    wire [`PCR_TOTAL_W:0] sum_w;
    wire [`PCR_TOTAL_W-1:0] total_d;
    wire reached_w;

    assign active_w = quota_enable & ~quota_clear;
    assign sum_w = {1'b0, total_q} + {{(`PCR_TOTAL_W + 1 - DELTA_W){1'b0}}, charge_delta};
    // saturate rather than wrap, so a full count never looks small again
    assign total_d = sum_w[`PCR_TOTAL_W] ? {`PCR_TOTAL_W{1'b1}} : sum_w[`PCR_TOTAL_W-1:0];
    // threshold step is 1024 total steps
    assign reached_w = (total_d[`PCR_TOTAL_W-1:`PCR_SCALE_SHIFT] >= threshold);

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            total_q <= {`PCR_TOTAL_W{1'b0}};
            hit_q <= 1'b0;
            alert_q <= 1'b0;
            open_q <= 1'b0;
            sleep_q <= 1'b0;
        end else if (!active_w) begin
            // disable or clear withdraws everything
            total_q <= {`PCR_TOTAL_W{1'b0}};
            hit_q <= 1'b0;
            alert_q <= 1'b0;
            open_q <= 1'b0;
            sleep_q <= 1'b0;
        end else if (update) begin
            // holds otherwise, so totals survive inactive and sleep periods
            total_q <= total_d;
            if (reached_w && !hit_q) begin
                hit_q <= 1'b1;
                case (quota_response)
                    `PCR_RESP_REPORT: begin
                        alert_q <= 1'b1;
                    end
                    `PCR_RESP_REPORT_DISC: begin
                        alert_q <= 1'b1;
                        open_q <= 1'b1;
                    end
                    `PCR_RESP_DISC_SLEEP: begin
                        open_q <= 1'b1;
                        sleep_q <= 1'b1;
                    end
                    default: begin
                        alert_q <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

//--- verilog/pcr_rationing.v
`timescale 1ns/1ps
`include "pcr_consts.vh"

module pcr_rationing #(
    parameter DELTA_W = 16,
    parameter UPDATE_CYCLES = `PCR_UPDATE_TIME_NS / `PCR_CLK_PERIOD_NS
) (
    // clock and reset
    input wire clk_sys,
    input wire arst_n,
    // register byte port behind the serial engine
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata_q,
    // power state and measured charge per second
    input wire power_active,
    input wire [DELTA_W-1:0] port1_charge_delta,
    input wire [DELTA_W-1:0] port2_charge_delta,
    // status and responses
    output reg port1_quota_hit_flag,
    output reg port2_quota_hit_flag,
    output reg port1_alert_req,
    output reg port2_alert_req,
    output reg port1_switch_open,
    output reg port2_switch_open,
    output reg sleep_req
);

    localparam TICK_W = 32;
    localparam [TICK_W-1:0] TICK_LAST = UPDATE_CYCLES - 1;

    reg [TICK_W-1:0] tick_cnt_q;
    reg update_q;
    reg [7:0] config_q;
    reg [`PCR_THRESH_W-1:0] thresh1_q;
    reg [`PCR_THRESH_W-1:0] thresh2_q;
    reg [31:0] snap1_q;
    reg [31:0] snap2_q;
    reg [7:0] rdata_d;

    wire [`PCR_TOTAL_W-1:0] total_w [0:1];
    wire [1:0] hit_w;
    wire [1:0] alert_w;
    wire [1:0] open_w;
    wire [1:0] sleep_w;
    wire [31:0] word1_w;
    wire [31:0] word2_w;

    // one second time base; only runs while active, so an update is issued on an active edge and applied one edge later, even if power has dropped
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_q <= {TICK_W{1'b0}};
            update_q <= 1'b0;
        end else if (!power_active) begin
            update_q <= 1'b0;
        end else if (tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= {TICK_W{1'b0}};
            update_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            update_q <= 1'b0;
        end
    end

    // config and threshold writes
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            config_q <= `PCR_CONFIG_RESET;
            thresh1_q <= `PCR_THRESH_RESET;
            thresh2_q <= `PCR_THRESH_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `PCR_ADDR_CONFIG: begin
                    config_q <= reg_wdata;
                end
                `PCR_ADDR_P1_THRESH: begin
                    thresh1_q[15:8] <= reg_wdata;
                end
                `PCR_ADDR_P1_THRESH + `PCR_BYTE1: begin
                    thresh1_q[7:0] <= reg_wdata;
                end
                `PCR_ADDR_P2_THRESH: begin
                    thresh2_q[15:8] <= reg_wdata;
                end
                `PCR_ADDR_P2_THRESH + `PCR_BYTE1: begin
                    thresh2_q[7:0] <= reg_wdata;
                end
                default: begin
                    config_q <= config_q;
                end
            endcase
        end
    end

    // per-port engines
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
            pcr_port_unit #(
                .DELTA_W(DELTA_W)
            ) u_port (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .update(update_q),
                .quota_enable(config_q[gi*`PCR_CFG_NIBBLE + `PCR_CFG_ENABLE_BIT]),
                .quota_clear(config_q[gi*`PCR_CFG_NIBBLE + `PCR_CFG_CLEAR_BIT]),
                .quota_response(config_q[gi*`PCR_CFG_NIBBLE + `PCR_CFG_RESP_LSB +: 2]),
                .threshold(gi == 0 ? thresh1_q : thresh2_q),
                .charge_delta(gi == 0 ? port1_charge_delta : port2_charge_delta),
                .total_q(total_w[gi]),
                .hit_q(hit_w[gi]),
                .alert_q(alert_w[gi]),
                .open_q(open_w[gi]),
                .sleep_q(sleep_w[gi])
            );
        end
    endgenerate

    // left-justified view, low pad reads zero
    assign word1_w = {total_w[0], {`PCR_PAD_BITS{1'b0}}};
    assign word2_w = {total_w[1], {`PCR_PAD_BITS{1'b0}}};

    // reading the top byte freezes the whole word, so a burst never tears across an update
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            snap1_q <= 32'h00000000;
            snap2_q <= 32'h00000000;
        end else if (reg_rd) begin
            if (reg_addr == `PCR_ADDR_P1_TOTAL) begin
                snap1_q <= word1_w;
            end
            if (reg_addr == `PCR_ADDR_P2_TOTAL) begin
                snap2_q <= word2_w;
            end
        end
    end

    always @* begin
        case (reg_addr)
            `PCR_ADDR_P1_TOTAL: rdata_d = word1_w[31:24];
            `PCR_ADDR_P1_TOTAL + `PCR_BYTE1: rdata_d = snap1_q[23:16];
            `PCR_ADDR_P1_TOTAL + `PCR_BYTE2: rdata_d = snap1_q[15:8];
            `PCR_ADDR_P1_TOTAL + `PCR_BYTE3: rdata_d = snap1_q[7:0];
            `PCR_ADDR_P2_TOTAL: rdata_d = word2_w[31:24];
            `PCR_ADDR_P2_TOTAL + `PCR_BYTE1: rdata_d = snap2_q[23:16];
            `PCR_ADDR_P2_TOTAL + `PCR_BYTE2: rdata_d = snap2_q[15:8];
            `PCR_ADDR_P2_TOTAL + `PCR_BYTE3: rdata_d = snap2_q[7:0];
            `PCR_ADDR_P1_THRESH: rdata_d = thresh1_q[15:8];
            `PCR_ADDR_P1_THRESH + `PCR_BYTE1: rdata_d = thresh1_q[7:0];
            `PCR_ADDR_P2_THRESH: rdata_d = thresh2_q[15:8];
            `PCR_ADDR_P2_THRESH + `PCR_BYTE1: rdata_d = thresh2_q[7:0];
            `PCR_ADDR_CONFIG: rdata_d = config_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end
    end

    // output stage; costs one cycle but keeps every pin on a local flop
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            port1_quota_hit_flag <= 1'b0;
            port2_quota_hit_flag <= 1'b0;
            port1_alert_req <= 1'b0;
            port2_alert_req <= 1'b0;
            port1_switch_open <= 1'b0;
            port2_switch_open <= 1'b0;
            sleep_req <= 1'b0;
        end else begin
            port1_quota_hit_flag <= hit_w[0];
            port2_quota_hit_flag <= hit_w[1];
            port1_alert_req <= alert_w[0];
            port2_alert_req <= alert_w[1];
            port1_switch_open <= open_w[0];
            port2_switch_open <= open_w[1];
            sleep_req <= sleep_w[0] | sleep_w[1];
        end
    end

endmodule
